// [logic/ccmm_defines.svh]
// Purpose: shared constants of the cascade serial link
// Assumes: 16-bit words, one word per frame
// Notes:   field positions, register codes, reset values and counts
`ifndef CCMM_DEFINES_SVH
`define CCMM_DEFINES_SVH
// ****************************************
// word layout
// ****************************************
`define CCMM_CTL_BIT    15
`define CCMM_ADDR_MSB   14
`define CCMM_ADDR_LSB   12
`define CCMM_REG_MSB    11
`define CCMM_REG_LSB    9
`define CCMM_DATA_MSB   8
`define CCMM_REG_MODE   3'h0
`define CCMM_REG_CLK    3'h1
`define CCMM_REG_CHAN   3'h3
`define CCMM_FAR_ADDR   3'h1
`define CCMM_NEAR_ADDR  3'h0
`define CCMM_INVALID    16'h7fff
// ****************************************
// reset values and timing counts
// ****************************************
`define CCMM_CLK_RST    4'h0
`define CCMM_CNT_RST    3'h1
`define CCMM_HALF_MIN   7'h08
`define CCMM_SMP_BASE   10'h040
// ****************************************
// host register offsets
// ****************************************
`define CCMM_OFF_CTRL   8'h00
`define CCMM_OFF_FAR    8'h04
`define CCMM_OFF_NEAR   8'h08
`define CCMM_OFF_STAT   8'h0c
`define CCMM_OFF_RXD    8'h10
`endif

// [logic/ccmm_pkg.sv]
// Purpose: types of the cascade serial link
// Assumes: nothing
// Notes:   mode codes and register state of both ends
`default_nettype none
package ccmm_pkg;
	typedef enum logic [1:0]
	{
		CCMM_PROG  = 2'h0,
		CCMM_DATA  = 2'h1,
		CCMM_MIXED = 2'h2
	} ccmm_mode_t;

	typedef struct packed {
		logic [6:0]  div;
		logic        sclk;
		logic [9:0]  smp;
		ccmm_mode_t  mode;
		logic [2:0]  count;
		logic [3:0]  clkcfg;
		logic [5:0]  pwr;
		logic [17:0] gain;
		logic        ofs;
		logic        sdo;
		logic        tx_act;
		logic [3:0]  tx_cnt;
		logic [15:0] tx_sr;
		logic        own_pend;
		logic        fwd_pend;
		logic [15:0] fwd_word;
		logic        rx_act;
		logic [3:0]  rx_cnt;
		logic [15:0] rx_sr;
	} ccmm_dev_st_t;

	typedef struct packed {
		logic        sclk_p;
		logic        ifs;
		logic        sdi;
		logic        tx_act;
		logic [4:0]  tx_cnt;
		logic [31:0] tx_sr;
		logic        pend;
		logic        rx_act;
		logic [3:0]  rx_cnt;
		logic [15:0] rx_sr;
		logic [1:0]  gap;
		logic        mixed;
		logic [7:0]  vcount;
		logic [15:0] rxd;
		logic [15:0] far;
		logic [15:0] near;
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} ccmm_host_st_t;
endpackage
`default_nettype wire

// [logic/ccmm_link_if.sv]
// Purpose: framed serial link between host and first device
// Assumes: device end makes the serial clock
// Notes:   in a cascade the bench chains device links itself
`timescale 1ns/100ps
`default_nettype none
interface ccmm_link_if;
	logic serial_clock;
	logic output_frame_sync;
	logic serial_out;
	logic input_frame_sync;
	logic serial_in;

	modport dev
	(
		output serial_clock,
		output output_frame_sync,
		output serial_out,
		input  input_frame_sync,
		input  serial_in
	);

	modport host
	(
		input  serial_clock,
		input  output_frame_sync,
		input  serial_out,
		output input_frame_sync,
		output serial_in
	);
endinterface
`default_nettype wire

// [logic/ccmm_sync.sv]
// Purpose: two-flop synchroniser for link inputs
// Assumes: inputs are levels from outside ref_clk
// Notes:   first stage feeds only the second
`timescale 1ns/100ps
`default_nettype none
module ccmm_sync
#(
	parameter int W = 2
)
(
	input  wire logic         ref_clk, // system clock
	input  wire logic         reset_n, // async reset
	input  wire logic [W-1:0] din,     // raw pins
	output logic      [W-1:0] dout     // synchronised
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} ccmm_sync_st_t;

	ccmm_sync_st_t q;
	ccmm_sync_st_t d;

	// shift through two stages
	always_comb
	begin
		d.s1 = din;
		d.s2 = q.s1;
	end

	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
			q <= '0;
		else
			q <= d;
	end

	assign dout = q.s2;
endmodule
`default_nettype wire

// [logic/ccmm_dev.sv]
// Purpose: one converter end of the cascaded framed serial link
// Assumes: no frame-sync loop-back; upstream word arrives on input pins
// Notes:   makes its own serial clock from ref_clk by a divider
//
// Operation
// [R01] all devices frame together on first event
// [R02] upstream output sync feeds downstream input sync
// [R03] host alone chooses words sent per interval
// [R04] program mode: one output event per sample
// [R05] program-phase converter words invalid, host discards
// [R06] foreign control word: decrement address, forward
// [R07] host sends near word while far forwarded
// [R08] serial-port words reach all devices together
// [R09] clock word sets serial and sample rate
// [R10] each interval all devices frame own result
// [R11] host writes never cross into next interval
// [R12] host order: far word, then near word
// [R13] channel word powers channels, sets gains
// [R14] mode word sets count and mixed mode
// [R15] host sends cascade words with no gap
// [R16] valid words follow the switch to mixed
// [R17] far word enters first device with address 001
// [R18] no valid words before mixed or data
// [R19] address zero: apply locally, do not forward
//
// Added by the designer: the APB slave port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module ccmm_dev
	import ccmm_pkg::*;
(
	input  wire logic  ref_clk,   // system clock, 200 MHz
	input  wire logic  reset_n,   // async reset, active low
	ccmm_link_if.dev   lnk,       // serial link pins
	input  wire logic [14:0] adc_word, // current conversion result
	output ccmm_mode_t mode,      // operating mode
	output logic [2:0] dev_count, // devices in the cascade
	output logic [3:0] clk_cfg,   // serial and sample rate codes
	output logic [5:0] chan_pwr,  // channel power-up mask
	output logic [17:0] chan_gain // gain code per channel, 3 bits each
);
	`include "ccmm_defines.svh"

	ccmm_dev_st_t q;
	ccmm_dev_st_t d;
	logic [1:0]   pin_s;
	logic         ifs_s;
	logic         sdi_s;
	logic [6:0]   half;
	logic [9:0]   period;
	logic [17:0]  gain_new;
	logic [15:0]  rx_w;

	// ****************************************
	// input pins
	// ****************************************
	ccmm_sync #(.W(2)) u_sync
	(
		.ref_clk (ref_clk),
		.reset_n (reset_n),
		.din     ({lnk.input_frame_sync, lnk.serial_in}),
		.dout    (pin_s)
	);
	assign ifs_s = pin_s[1];
	assign sdi_s = pin_s[0];

	// rate codes scale the clock and sample interval
	assign half   = `CCMM_HALF_MIN << q.clkcfg[1:0]; // R09
	assign period = `CCMM_SMP_BASE << q.clkcfg[3:2]; // R09
	assign rx_w   = {q.rx_sr[14:0], sdi_s};

	// ****************************************
	// per-channel gain update
	// ****************************************
	genvar gi;
	generate
		for (gi = 0; gi < 6; gi++)
		begin : g_gain
			assign gain_new[gi*3 +: 3] = rx_w[gi] ?
				rx_w[`CCMM_DATA_MSB -: 3] : q.gain[gi*3 +: 3]; // R13
		end
	endgenerate

	// ****************************************
	// next state
	// ****************************************
	always_comb
	begin
		logic        rise;
		logic        fall;
		logic        free;
		logic        sample;
		logic [15:0] own;
		rise   = 1'b0;
		fall   = 1'b0;
		free   = 1'b0;
		sample = 1'b0;
		own    = `CCMM_INVALID;
		d      = q;

		// divider; >= copes with a rate change mid half-period
		if (q.div >= half - 7'h01)
		begin
			d.div  = 7'h00;
			d.sclk = ~q.sclk;
			rise   = ~q.sclk;
			fall   = q.sclk;
		end
		else
			d.div = q.div + 7'h01;

		// invalid words until mixed or data mode
		if (q.mode != CCMM_PROG)
			own = {1'b0, adc_word}; // R18 R16

		// transmit on rising edges
		if (rise)
		begin
			// smp starts at zero so the first edge after reset frames every device at once
			sample = (q.smp == 10'h000); // R01
			d.smp  = (q.smp >= period - 10'h001) ? 10'h000 : q.smp + 10'h001;
			free   = !q.tx_act || (q.tx_cnt == 4'hf);
			if (q.tx_act)
			begin
				d.ofs    = 1'b0;
				d.sdo    = q.tx_sr[14];
				d.tx_sr  = {q.tx_sr[14:0], 1'b0};
				d.tx_cnt = q.tx_cnt + 4'h1;
				if (q.tx_cnt == 4'hf)
				begin
					d.tx_act = 1'b0;
					d.sdo    = 1'b0;
				end
			end
			// one own word per interval, ahead of forwarded words
			if (free && (sample || q.own_pend))
			begin
				d.tx_act   = 1'b1; // R04 R10
				d.tx_cnt   = 4'h0;
				d.tx_sr    = own;
				d.sdo      = own[15];
				d.ofs      = 1'b1;
				d.own_pend = 1'b0;
			end
			else if (free && q.fwd_pend)
			begin
				d.tx_act   = 1'b1; // R06
				d.tx_cnt   = 4'h0;
				d.tx_sr    = q.fwd_word;
				d.sdo      = q.fwd_word[15];
				d.ofs      = 1'b1;
				d.fwd_pend = 1'b0;
			end
			else if (sample)
				d.own_pend = 1'b1;
		end

		// receive on falling edges
		if (fall)
		begin
			if (q.rx_act)
			begin
				d.rx_sr  = rx_w;
				d.rx_cnt = q.rx_cnt + 4'h1;
				if (q.rx_cnt == 4'hf)
				begin
					d.rx_act = 1'b0;
					if (rx_w[`CCMM_CTL_BIT])
					begin
						if (rx_w[`CCMM_ADDR_MSB:`CCMM_ADDR_LSB] != 3'h0)
						begin
							// forward on the next rising edge, no gap
							d.fwd_pend = 1'b1; // R06
							d.fwd_word = rx_w;
							d.fwd_word[`CCMM_ADDR_MSB:`CCMM_ADDR_LSB] =
								rx_w[`CCMM_ADDR_MSB:`CCMM_ADDR_LSB] - 3'h1;
						end
						else if (q.mode != CCMM_DATA)
						begin
							// addressed here; data mode ignores control words
							case (rx_w[`CCMM_REG_MSB:`CCMM_REG_LSB]) // R19
								`CCMM_REG_MODE:
								begin
									d.mode  = ccmm_mode_t'(rx_w[1:0]); // R14
									d.count = rx_w[4:2]; // R14
								end
								`CCMM_REG_CLK:
									d.clkcfg = rx_w[3:0]; // R09
								`CCMM_REG_CHAN:
								begin
									d.pwr  = rx_w[5:0]; // R13
									d.gain = gain_new;
								end
								default:
									d.mode = q.mode;
							endcase
						end
					end
					else if (q.mode != CCMM_PROG && q.count > 3'h1)
					begin
						// upstream result passes on toward the host
						d.fwd_pend = 1'b1; // R10
						d.fwd_word = rx_w;
					end
				end
			end
			else if (ifs_s)
			begin
				d.rx_act = 1'b1;
				d.rx_cnt = 4'h1;
				d.rx_sr  = {15'h0000, sdi_s};
			end
		end
	end

	// ****************************************
	// state register
	// ****************************************
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			q        <= '0;
			q.mode   <= CCMM_PROG;
			q.count  <= `CCMM_CNT_RST;
			q.clkcfg <= `CCMM_CLK_RST;
		end
		else
			q <= d;
	end

	// ****************************************
	// outputs
	// ****************************************
	assign lnk.serial_clock      = q.sclk;
	assign lnk.output_frame_sync = q.ofs;
	assign lnk.serial_out        = q.sdo;
	assign mode                  = q.mode;
	assign dev_count             = q.count;
	assign clk_cfg               = q.clkcfg;
	assign chan_pwr              = q.pwr;
	assign chan_gain             = q.gain;
endmodule
`default_nettype wire

// [logic/ccmm_host.sv]
// Purpose: host end; sends far/near control word pairs, collects results
// Assumes: two-device cascade, first device on this link
// Notes:   software reaches it over APB, one wait state per access
`timescale 1ns/100ps
`default_nettype none
module ccmm_host
	import ccmm_pkg::*;
(
	input  wire logic        ref_clk,  // system clock, 200 MHz
	input  wire logic        reset_n,  // async reset, active low
	ccmm_link_if.host        lnk,      // serial link pins
	input  wire logic        psel,     // apb select
	input  wire logic        penable,  // apb enable
	input  wire logic        pwrite,   // apb direction
	input  wire logic [7:0]  paddr,    // apb byte address
	input  wire logic [31:0] pwdata,   // apb write data
	output logic             pready,   // apb ready
	output logic             pslverr,  // apb error, unmapped address
	output logic [31:0]      prdata    // apb read data
);
	`include "ccmm_defines.svh"

	ccmm_host_st_t q;
	ccmm_host_st_t d;
	logic [2:0]    pin_s;
	logic          rise;
	logic          fall;
	logic [15:0]   rx_w;
	logic [31:0]   rd;
	logic          hit;

	// ****************************************
	// input pins
	// ****************************************
	ccmm_sync #(.W(3)) u_sync
	(
		.ref_clk (ref_clk),
		.reset_n (reset_n),
		.din     ({lnk.serial_clock, lnk.output_frame_sync, lnk.serial_out}),
		.dout    (pin_s)
	);
	assign rise = pin_s[2] & ~q.sclk_p;
	assign fall = ~pin_s[2] & q.sclk_p;
	assign rx_w = {q.rx_sr[14:0], pin_s[0]};

	// read mux
	always_comb
	begin
		hit = 1'b1;
		rd  = 32'h0000_0000;
		case (paddr)
			`CCMM_OFF_CTRL: rd = 32'h0000_0000;
			`CCMM_OFF_FAR:  rd = {16'h0000, q.far};
			`CCMM_OFF_NEAR: rd = {16'h0000, q.near};
			`CCMM_OFF_STAT: rd = {16'h0000, q.vcount, 5'h00, q.tx_act, q.mixed, q.pend};
			`CCMM_OFF_RXD:  rd = {16'h0000, q.rxd};
			default:        hit = 1'b0;
		endcase
	end

	// ****************************************
	// next state
	// ****************************************
	always_comb
	begin
		d        = q;
		d.sclk_p = pin_s[2];

		// transmit on rising edges
		if (rise)
		begin
			if (pin_s[1])
				d.gap = 2'h0;
			else if (!q.rx_act && q.gap != 2'h3)
				d.gap = q.gap + 2'h1;
			if (q.tx_act)
			begin
				d.sdi    = q.tx_sr[30];
				d.tx_sr  = {q.tx_sr[30:0], 1'b0};
				d.tx_cnt = q.tx_cnt + 5'h01;
				d.ifs    = (q.tx_cnt == 5'h0f); // R15
				if (q.tx_cnt == 5'h1f)
				begin
					d.tx_act = 1'b0;
					d.sdi    = 1'b0;
					d.ifs    = 1'b0;
					// valid results follow a mode word that leaves program mode
					if (q.far[`CCMM_REG_MSB:`CCMM_REG_LSB] == `CCMM_REG_MODE)
						d.mixed = (q.far[1:0] != CCMM_PROG); // R16
				end
			end
			// only at an interval start, so the pair ends well before the next
			else if (pin_s[1] && q.gap[1] && q.pend) // R03 R11
			begin
				d.tx_act = 1'b1;
				d.tx_cnt = 5'h00;
				// far word first with address 001, then near word
				d.tx_sr  = {q.far[15], `CCMM_FAR_ADDR, q.far[11:0],
					q.near[15], `CCMM_NEAR_ADDR, q.near[11:0]}; // R12 R17 R07 R08
				d.sdi    = q.far[15];
				d.ifs    = 1'b1;
				d.pend   = 1'b0;
			end
		end

		// receive on falling edges
		if (fall)
		begin
			if (q.rx_act)
			begin
				d.rx_sr  = rx_w;
				d.rx_cnt = q.rx_cnt + 4'h1;
				if (q.rx_cnt == 4'hf)
				begin
					d.rx_act = 1'b0;
					// programming-phase results are dropped
					if (q.mixed && !rx_w[`CCMM_CTL_BIT]) // R05
					begin
						d.rxd    = rx_w;
						d.vcount = q.vcount + 8'h01;
					end
				end
			end
			else if (pin_s[1])
			begin
				d.rx_act = 1'b1;
				d.rx_cnt = 4'h1;
				d.rx_sr  = {15'h0000, pin_s[0]};
			end
		end

		// apb: ready one cycle into access, write on the ready edge
		d.pready = 1'b0;
		if (psel && penable && !q.pready)
		begin
			d.pready  = 1'b1;
			d.prdata  = rd;
			d.pslverr = ~hit;
		end
		if (psel && penable && q.pready && pwrite)
		begin
			case (paddr)
				`CCMM_OFF_CTRL: d.pend = q.pend | pwdata[0];
				`CCMM_OFF_FAR:  d.far  = pwdata[15:0];
				`CCMM_OFF_NEAR: d.near = pwdata[15:0];
				default:        d.pend = d.pend;
			endcase
		end
	end

	// ****************************************
	// state register
	// ****************************************
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			q     <= '0;
			q.gap <= 2'h3; // first frame after reset counts as an interval start
		end
		else
			q <= d;
	end

	// ****************************************
	// outputs
	// ****************************************
	assign lnk.input_frame_sync = q.ifs;
	assign lnk.serial_in        = q.sdi;
	assign pready               = q.pready;
	assign pslverr              = q.pslverr;
	assign prdata               = q.prdata;
endmodule
`default_nettype wire

// [dv/ccmm_cascade_monitor.sv]
// Purpose: link checks on the host side of the cascade
// Assumes: serial rate code stays 0, so a half period is 8 ref clocks
// Notes:   watches only the link that faces the host
`timescale 1ns/100ps
`default_nettype none
module ccmm_cascade_monitor
(
	input wire logic ref_clk,           // system clock
	input wire logic reset_n,           // async reset
	input wire logic serial_clock,      // link clock of last end
	input wire logic output_frame_sync, // sync of last end
	input wire logic serial_out,        // data of last end
	input wire logic input_frame_sync,  // host sync
	input wire logic serial_in          // host data
);
	// ****************************
	// helpers
	// ****************************
	logic [7:0] ofs_len_q; // cycles of sync high so far
	logic [7:0] since_q;   // cycles since sync rose, saturating
	logic       ifs_q;     // host sync one cycle ago
	logic       par_q;     // high after first word of a pair
	// counters restart on sync edges so each frame is judged alone
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			ofs_len_q <= 8'h00;
			since_q <= 8'hff;
			ifs_q <= 1'b0;
			par_q <= 1'b0;
		end
		else
		begin
			ofs_len_q <= output_frame_sync ? ofs_len_q + 8'h01 : 8'h00;
			if (output_frame_sync && ofs_len_q == 8'h00)
				since_q <= 8'h00;
			else if (since_q != 8'hff)
				since_q <= since_q + 8'h01;
			ifs_q <= input_frame_sync;
			if (input_frame_sync && !ifs_q)
				par_q <= !par_q;
		end
	end

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	sequence s_high8;
		serial_clock [*8];
	endsequence
	sequence s_low8;
		!serial_clock [*8];
	endsequence

	AST_SCLK_HIGH: assert property ($rose(serial_clock) |-> s_high8 ##1 !serial_clock)
		else $error("link clock high phase not 8 cycles");
	AST_SCLK_LOW: assert property ($fell(serial_clock) |-> s_low8)
		else $error("link clock low phase too short");
	AST_FIRST_FRAME: assert property ($rose(reset_n) |-> ##[1:48] output_frame_sync)
		else $error("no frame soon after reset");
	AST_OFS_WIDTH: assert property ($fell(output_frame_sync) |-> $past(ofs_len_q) == 8'd15)
		else $error("output sync not one bit long");
	AST_OFS_AT_RISE: assert property ($rose(output_frame_sync) |-> serial_clock)
		else $error("output sync off the clock rise");
	AST_SDO_CHANGE: assert property ($changed(serial_out) |-> serial_clock)
		else $error("device data moved in low phase");
	AST_SDI_CHANGE: assert property ($changed(serial_in) |-> serial_clock)
		else $error("host data moved in low phase");
	AST_PAIR_GAP: assert property ($rose(input_frame_sync) && !par_q |-> ##[255:257] $rose(input_frame_sync))
		else $error("gap between far and near word");
	AST_PAIR_ON_FRAME: assert property ($rose(input_frame_sync) && !par_q |-> since_q < 8'd80)
		else $error("pair not started on an output frame");
endmodule
`default_nettype wire

// [dv/cascade_mixed_mode_programming_bench.sv]
// Purpose: host plus two cascaded converter ends, checked at their user sides
// Assumes: serial rate code kept 0 throughout
// Notes:   host feeds first end, last end answers host
`timescale 1ns/100ps
`default_nettype none
`include "ccmm_defines.svh"
module cascade_mixed_mode_programming_bench
	import ccmm_pkg::*;
;
	// ****************************
	// signals and instances
	// ****************************
	logic        ref_clk = 1'b0;
	logic        reset_n = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [14:0] adc1 = 15'h1234;
	logic [14:0] adc2 = 15'h0567;
	ccmm_mode_t  m1, m2;
	logic [2:0]  n1, n2;
	logic [3:0]  k1, k2;
	logic [5:0]  p1, p2;
	logic [17:0] g1, g2;
	logic [31:0] r;
	logic        e;
	int          n_fail = 0;
	int          tests_run = 0;
	ccmm_link_if la();
	ccmm_link_if lb();
	ccmm_link_if lh();
	// first end output feeds second end input
	assign lb.input_frame_sync = la.output_frame_sync;
	assign lb.serial_in = la.serial_out;
	assign la.input_frame_sync = lh.input_frame_sync;
	assign la.serial_in = lh.serial_in;
	assign lh.serial_clock = lb.serial_clock;
	assign lh.output_frame_sync = lb.output_frame_sync;
	assign lh.serial_out = lb.serial_out;
	always #2.5 ref_clk = ~ref_clk;
	ccmm_dev ccmm_dev_1_i (.ref_clk(ref_clk), .reset_n(reset_n), .lnk(la), .adc_word(adc1), .mode(m1),
		.dev_count(n1), .clk_cfg(k1), .chan_pwr(p1), .chan_gain(g1));
	ccmm_dev ccmm_dev_2_i (.ref_clk(ref_clk), .reset_n(reset_n), .lnk(lb), .adc_word(adc2), .mode(m2),
		.dev_count(n2), .clk_cfg(k2), .chan_pwr(p2), .chan_gain(g2));
	ccmm_host ccmm_host_i (.ref_clk(ref_clk), .reset_n(reset_n), .lnk(lh), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata));
	ccmm_cascade_monitor ccmm_cascade_monitor_i (.ref_clk(ref_clk), .reset_n(reset_n),
		.serial_clock(lh.serial_clock), .output_frame_sync(lh.output_frame_sync), .serial_out(lh.serial_out),
		.input_frame_sync(lh.input_frame_sync), .serial_in(lh.serial_in));
	// ****************************
	// shared tasks
	// ****************************
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// one apb transfer, held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		// no cycle count assumed; only the watchdog ends a hung wait
		do
			@(posedge ref_clk);
		while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	function automatic logic [15:0] cw(input logic [2:0] a, input logic [2:0] rg, input logic [8:0] d);
		return {1'b1, a, rg, d};
	endfunction
	// pair goes out at the next interval; the forwarded word lands one frame later
	task automatic pair(input logic [15:0] fw, input logic [15:0] nw);
		apb(1'b1, `CCMM_OFF_FAR, {16'h0, fw});
		apb(1'b1, `CCMM_OFF_NEAR, {16'h0, nw});
		apb(1'b1, `CCMM_OFF_CTRL, 32'h1);
		// poll until the pair has left; the watchdog guards a hang
		do
			apb(1'b0, `CCMM_OFF_STAT, 32'h0);
		while ((r[0] | r[2]) !== 1'b0);
		repeat (400) @(posedge ref_clk);
	endtask
	// ****************************
	// scenarios
	// ****************************
	task automatic t_reset();
		check("mode1", m1, CCMM_PROG);
		check("mode2", m2, CCMM_PROG);
		check("count2", n2, `CCMM_CNT_RST);
		check("clk1", k1, `CCMM_CLK_RST);
		apb(1'b0, 8'h20, 32'h0);
		check("unmapped err", e, 1'b1);
		check("unmapped data", r, 32'h0);
		$display("test reset done");
	endtask
	task automatic t_clk();
		pair(cw(`CCMM_FAR_ADDR, `CCMM_REG_CLK, 9'h004), cw(`CCMM_NEAR_ADDR, `CCMM_REG_CLK, 9'h004));
		check("clk1", k1, 4'h4);
		check("clk2", k2, 4'h4);
		check("mode2", m2, CCMM_PROG);
		$display("test clock word done");
	endtask
	// different words per end show the routing and the decrement
	task automatic t_chan();
		pair(cw(`CCMM_FAR_ADDR, `CCMM_REG_CHAN, 9'h083), cw(`CCMM_NEAR_ADDR, `CCMM_REG_CHAN, 9'h0cc));
		check("pwr2", p2, 6'h03);
		check("gain2", g2, 18'h00012);
		check("pwr1", p1, 6'h0c);
		check("gain1", g1, 18'h006c0);
		apb(1'b0, `CCMM_OFF_STAT, 32'h0);
		check("no valid", r[15:8], 8'h00);
		apb(1'b0, `CCMM_OFF_NEAR, 32'h0);
		check("near readback", r, {16'h0, cw(`CCMM_NEAR_ADDR, `CCMM_REG_CHAN, 9'h0cc)});
		$display("test channel word done");
	endtask
	task automatic t_mixed();
		int i;
		logic s1, s2;
		s1 = 1'b0;
		s2 = 1'b0;
		pair(cw(`CCMM_FAR_ADDR, `CCMM_REG_MODE, 9'h00a), cw(`CCMM_NEAR_ADDR, `CCMM_REG_MODE, 9'h00a));
		check("mode1", m1, CCMM_MIXED);
		check("mode2", m2, CCMM_MIXED);
		check("count1", n1, 3'h2);
		check("count2", n2, 3'h2);
		for (i = 0; i < 2000 && !(s1 && s2); i++)
		begin
			apb(1'b0, `CCMM_OFF_RXD, 32'h0);
			s1 = s1 | (r === {17'h0, adc1});
			s2 = s2 | (r === {17'h0, adc2});
		end
		check("first end word", s1, 1'b1);
		check("last end word", s2, 1'b1);
		apb(1'b0, `CCMM_OFF_STAT, 32'h0);
		check("valid mode", r[1], 1'b1);
		$display("test mixed mode done");
	endtask
	// data mode keeps delivering results but refuses words addressed to an end
	task automatic t_data();
		pair(cw(`CCMM_FAR_ADDR, `CCMM_REG_MODE, 9'h009), cw(`CCMM_NEAR_ADDR, `CCMM_REG_MODE, 9'h009));
		check("data mode1", m1, CCMM_DATA);
		check("data mode2", m2, CCMM_DATA);
		check("data count2", n2, 3'h2);
		pair(cw(`CCMM_FAR_ADDR, `CCMM_REG_CLK, 9'h008), cw(`CCMM_NEAR_ADDR, `CCMM_REG_CLK, 9'h008));
		check("clk1 kept", k1, 4'h4);
		check("clk2 kept", k2, 4'h4);
		apb(1'b0, `CCMM_OFF_STAT, 32'h0);
		check("valid count", r[15:8] != 8'h00, 1'b1);
		$display("test data mode done");
	endtask
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// ****************************
	// sequence and watchdog
	// ****************************
	initial
	begin
		repeat (5) @(posedge ref_clk);
		reset_n <= 1'b1;
		t_reset();
		t_clk();
		t_chan();
		t_mixed();
		t_data();
		final_report();
	end
	// about 12k cycles expected, limit at 80k
	initial
	begin
		#400000;
		n_fail++;
		final_report();
	end
endmodule
`default_nettype wire
